// *** irig_master_ctrl.sv ***
// time-code master: frame timing, local clock, leap second, host controls
// Behaviour
// RULE1: once enabled, emit frames continuously until stopped
// RULE2: disable stops driving time-code frames
// RULE3: status reads 1 when active, else 0
// RULE4: master reset clears all programmed settings; the code keeps the local time loaded by time_wr
// RULE5: control bits register holds 18 embedded bits
// RULE6: control bits write stores, read returns stored
// RULE7: leap second inserted at 59:59 of hour
// RULE8: leap year, day, hour kept and readable
// RULE9: leap holds one extra second, then clears
module irig_master_ctrl
  import irig_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic out_enable,
  input wire logic out_disable,
  input wire logic out_reset,
  output logic out_status,
  input wire logic cfg_wr,
  input wire logic cfg_type_in,
  input wire logic [3:0] cfg_pin_in,
  output logic cfg_type,
  output logic [3:0] cfg_pin,
  input wire logic ctrl_wr,
  input wire logic [CTRL_W-1:0] ctrl_wdata,
  output logic [CTRL_W-1:0] ctrl_rdata,
  input wire logic leap_wr,
  input wire logic [6:0] leap_year_in,
  input wire logic [8:0] leap_day_in,
  input wire logic [4:0] leap_hour_in,
  output logic [6:0] leap_year,
  output logic [8:0] leap_day,
  output logic [4:0] leap_hour,
  output logic leap_pending,
  input wire logic time_wr,
  input wire logic [6:0] time_year_in,
  input wire logic [8:0] time_day_in,
  input wire logic [4:0] time_hour_in,
  input wire logic [5:0] time_min_in,
  input wire logic [5:0] time_sec_in,
  output logic tc_out,
  output logic tc_oe
);
  logic ms_tick;
  logic [3:0] ms_q;
  logic [6:0] bit_q;
  logic en_q;
  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic [4:0] hour_q;
  logic [8:0] day_q;
  logic [6:0] year_q;
  logic frame_end;
  logic leap_now;
  logic [99:0] frame;
  logic [3:0] width;

  ms_tick_gen #(.CYC_PER_MS(CYC_PER_MS_P)) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ms_tick(ms_tick)
  );

  function automatic logic [7:0] bcd2(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'd10;
    return {t[3:0], 4'(v - t * 7'd10)};
  endfunction : bcd2

  function automatic logic [9:0] bcd3(input logic [8:0] v);
    logic [8:0] h;
    logic [8:0] r;
    h = v / 9'd100;
    r = v - h * 9'd100;
    return {h[1:0], bcd2(r[6:0])};
  endfunction : bcd3

  ////////////////////////////////////////////////////////////////////////////
  // frame timing: 10 ms per bit, 100 bits per frame, one frame per second
  assign frame_end = ms_tick && (ms_q == MS_PER_BIT - 4'h1) && (bit_q == BITS_PER_FRAME - 7'h01);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ms_q <= 4'h0;
      bit_q <= 7'h00;
    end else if (ms_tick) begin
      if (ms_q == MS_PER_BIT - 4'h1) begin
        ms_q <= 4'h0;
        bit_q <= (bit_q == BITS_PER_FRAME - 7'h01) ? 7'h00 : bit_q + 7'h01;
      end else begin
        ms_q <= ms_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable, status and output gating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      en_q <= 1'b0;
      out_status <= 1'b0;
    end else if (out_reset || out_disable) begin
      en_q <= 1'b0; // see RULE4
      out_status <= 1'b0; // see RULE2 see RULE3
    end else begin
      if (out_enable) begin
        en_q <= 1'b1;
      end
      // output starts on a frame boundary so the receiver never sees a torn first frame
      if (frame_end && en_q) begin
        out_status <= 1'b1; // see RULE1 see RULE3
      end
    end
  end

  // status is the active flag itself // see RULE3

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_type <= TYPE_RESET;
      cfg_pin <= PIN_RESET;
    end else if (out_reset) begin
      cfg_type <= TYPE_RESET; // see RULE4
      cfg_pin <= PIN_RESET;
    end else if (cfg_wr) begin
      cfg_type <= cfg_type_in;
      cfg_pin <= cfg_pin_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_rdata <= CTRL_RESET;
    end else if (out_reset) begin
      ctrl_rdata <= CTRL_RESET; // see RULE4
    end else if (ctrl_wr) begin
      ctrl_rdata <= ctrl_wdata; // see RULE5 see RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // leap second schedule
  assign leap_now = leap_pending && (year_q == leap_year) && (day_q == leap_day) &&
                    (hour_q == leap_hour) && (min_q == LEAP_MIN) && (sec_q == LEAP_SEC);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      leap_year <= 7'h00;
      leap_day <= 9'h000;
      leap_hour <= 5'h00;
      leap_pending <= 1'b0;
    end else if (out_reset) begin
      leap_year <= 7'h00;
      leap_day <= 9'h000;
      leap_hour <= 5'h00;
      leap_pending <= 1'b0;
    end else if (leap_wr) begin
      leap_year <= leap_year_in; // see RULE8
      leap_day <= leap_day_in;
      leap_hour <= leap_hour_in;
      leap_pending <= 1'b1;
    end else if (frame_end && sec_q == SEC_LEAP_HOLD) begin
      leap_pending <= 1'b0; // see RULE9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local clock, advanced once per frame
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
      hour_q <= 5'h00;
      day_q <= DAY_FIRST;
      year_q <= 7'h00;
    end else if (time_wr) begin
      sec_q <= time_sec_in;
      min_q <= time_min_in;
      hour_q <= time_hour_in;
      day_q <= time_day_in;
      year_q <= time_year_in;
    end else if (frame_end) begin
      if (leap_now) begin
        sec_q <= SEC_LEAP_HOLD; // see RULE7 see RULE9
      end else if (sec_q < SEC_MAX) begin
        sec_q <= sec_q + 6'h01;
      end else begin
        sec_q <= 6'h00;
        if (min_q < MIN_MAX) begin
          min_q <= min_q + 6'h01;
        end else begin
          min_q <= 6'h00;
          if (hour_q < HOUR_MAX) begin
            hour_q <= hour_q + 5'h01;
          end else begin
            hour_q <= 5'h00;
            if (day_q < ((year_q[1:0] == 2'b00) ? DAY_MAX_LEAP : DAY_MAX)) begin
              day_q <= day_q + 9'h001;
            end else begin
              day_q <= DAY_FIRST;
              year_q <= (year_q == YEAR_MAX) ? 7'h00 : year_q + 7'h01;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame content and pulse width
  always_comb begin
    logic [7:0] s;
    logic [7:0] m;
    logic [7:0] h;
    logic [9:0] d;
    logic [7:0] y;
    s = bcd2({1'b0, sec_q});
    m = bcd2({1'b0, min_q});
    h = bcd2({2'b00, hour_q});
    d = bcd3(day_q);
    y = bcd2(year_q);
    frame = '0;
    frame[4:1] = s[3:0];
    frame[8:6] = s[6:4];
    frame[13:10] = m[3:0];
    frame[17:15] = m[6:4];
    frame[23:20] = h[3:0];
    frame[26:25] = h[5:4];
    frame[33:30] = d[3:0];
    frame[38:35] = d[7:4];
    frame[41:40] = d[9:8];
    frame[53:50] = y[3:0];
    frame[58:55] = y[7:4];
    frame[CTRL_LO_BIT+8:CTRL_LO_BIT] = ctrl_rdata[8:0]; // see RULE5
    frame[CTRL_HI_BIT+8:CTRL_HI_BIT] = ctrl_rdata[17:9];
  end

  always_comb begin
    if (bit_q == 7'h00 || bit_q % 7'd10 == 7'd9) begin
      width = W_MARK;
    end else if (frame[bit_q]) begin
      width = W_ONE;
    end else begin
      width = W_ZERO;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tc_out <= 1'b0;
      tc_oe <= 1'b0;
    end else begin
      tc_out <= out_status && (ms_q < width); // see RULE1 see RULE2
      tc_oe <= out_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  run_holds_a: assert property (out_status && !out_disable && !out_reset |=> out_status) // see RULE1
    else $error("time-code output stopped without request");
  stop_output_a: assert property (out_disable |=> !out_status ##1 (!tc_out && !tc_oe)) // see RULE2
    else $error("output still driven after disable");
  start_frame_a: assert property ($rose(out_status) |-> $past(frame_end) && $past(en_q)) // see RULE3
    else $error("status rose off a frame boundary");
  reset_clears_a: assert property (out_reset |=> ctrl_rdata == CTRL_RESET && cfg_pin == PIN_RESET &&
                                   !cfg_type && !out_status && !leap_pending) // see RULE4
    else $error("master reset left settings");
  ctrl_store_a: assert property (ctrl_wr && !out_reset |=> ctrl_rdata == $past(ctrl_wdata)) // see RULE6
    else $error("control bits not stored");
  ctrl_embed_a: assert property (frame[CTRL_LO_BIT] == ctrl_rdata[0] &&
                                 frame[CTRL_HI_BIT+8] == ctrl_rdata[CTRL_W-1]) // see RULE5
    else $error("control bits missing from frame");
  leap_insert_a: assert property (frame_end && leap_now && !time_wr |=> sec_q == SEC_LEAP_HOLD) // see RULE7
    else $error("leap second not inserted");
  leap_keep_a: assert property (leap_wr && !out_reset |=> leap_year == $past(leap_year_in) &&
                                leap_day == $past(leap_day_in) && leap_hour == $past(leap_hour_in)) // see RULE8
    else $error("leap schedule not retained");
  leap_done_a: assert property (frame_end && sec_q == SEC_LEAP_HOLD && !time_wr && !leap_wr && !out_reset
                                |=> sec_q == 6'h00 && min_q == 6'h00 && !leap_pending) // see RULE9
    else $error("leap hold not closed");

  enable_cov: cover property (en_q && !out_status ##1 out_status);
  leap_cov: cover property (leap_now && frame_end);
  ctrl_cov: cover property (ctrl_wr ##1 out_status);
endmodule : irig_master_ctrl

// *** irig_pkg.sv ***
// constants for the time-code master control block
package irig_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CTRL_W = 18;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 18'h00000;
  localparam logic [3:0] MS_PER_BIT = 4'ha;
  localparam logic [6:0] BITS_PER_FRAME = 7'h64;
  localparam logic [3:0] W_ZERO = 4'h2;
  localparam logic [3:0] W_ONE = 4'h5;
  localparam logic [3:0] W_MARK = 4'h8;
  localparam logic [5:0] LEAP_SEC = 6'h3b;
  localparam logic [5:0] LEAP_MIN = 6'h3b;
  localparam logic [5:0] SEC_LEAP_HOLD = 6'h3c;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [8:0] DAY_MAX = 9'h16d;
  localparam logic [8:0] DAY_MAX_LEAP = 9'h16e;
  localparam logic [8:0] DAY_FIRST = 9'h001;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [3:0] PIN_RESET = 4'h0;
  localparam logic TYPE_RESET = 1'b0;
  localparam int unsigned CTRL_LO_BIT = 60;
  localparam int unsigned CTRL_HI_BIT = 70;
endpackage : irig_pkg

// *** ms_tick_gen.sv ***
// millisecond enable pulse divided down from the system clock
module ms_tick_gen #(
  parameter int unsigned CYC_PER_MS = irig_pkg::CYC_PER_MS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic ms_tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (cnt_q == CYC_PER_MS - 1) begin
      cnt_q <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end
endmodule : ms_tick_gen

// *** tc_slave_model.sv ***
// behavioural time-code receiver that decodes pulse widths on the output pin
module tc_slave_model #(
  parameter int CPM = 4
) (
  input wire logic clk_sys,
  input wire logic tc_out,
  input wire logic tc_oe,
  output logic frame_ok,
  output logic [99:0] bits
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi = 0;
  int idx = 200;
  logic prev_mark = 1'b0;
  logic mark;
  // a released pin reads low through the receiver termination
  assign mark = hi > 6 * CPM;
  always @(posedge clk_sys) begin
    frame_ok <= 1'b0;
    if (tc_out && tc_oe) begin
      hi <= hi + 1;
    end else if (hi > 0) begin
      hi <= 0;
      prev_mark <= mark;
      // two markers in a row: the second one opens a frame
      if (mark && prev_mark) begin
        idx <= 1;
      end else begin
        if (idx < 100) begin
          bits[idx] <= hi > 3 * CPM && !mark;
        end
        idx <= idx + 1;
        frame_ok <= idx == 99;
      end
    end
  end
endmodule : tc_slave_model

// *** tb_irig_master_ctrl.sv ***
// self-checking bench for the time-code master control block
module tb_irig_master_ctrl;
  import irig_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rstn = 1'b0, out_enable = 1'b0, out_disable = 1'b0, out_reset = 1'b0;
  logic cfg_wr = 1'b0, cfg_type_in = 1'b0, ctrl_wr = 1'b0, leap_wr = 1'b0, time_wr = 1'b0;
  logic out_status, cfg_type, leap_pending, tc_out, tc_oe, frame_ok, seen;
  logic [3:0] cfg_pin_in = '0, cfg_pin;
  logic [CTRL_W-1:0] ctrl_wdata = '0, ctrl_rdata;
  logic [6:0] leap_year_in = '0, time_year_in = '0, leap_year;
  logic [8:0] leap_day_in = '0, time_day_in = '0, leap_day;
  logic [4:0] leap_hour_in = '0, time_hour_in = '0, leap_hour;
  logic [5:0] time_min_in = '0, time_sec_in = '0;
  logic [99:0] bits;
  logic [31:0] v;
  int failures = 0, comparisons = 0, cyc = 0, s, p;

  irig_master_ctrl #(.CYC_PER_MS_P(4)) uut (.clk_sys, .rstn, .out_enable, .out_disable, .out_reset,
    .out_status, .cfg_wr, .cfg_type_in, .cfg_pin_in, .cfg_type, .cfg_pin, .ctrl_wr, .ctrl_wdata,
    .ctrl_rdata, .leap_wr, .leap_year_in, .leap_day_in, .leap_hour_in, .leap_year, .leap_day,
    .leap_hour, .leap_pending, .time_wr, .time_year_in, .time_day_in, .time_hour_in, .time_min_in,
    .time_sec_in, .tc_out, .tc_oe);
  tc_slave_model #(.CPM(4)) rx (.clk_sys, .tc_out, .tc_oe, .frame_ok, .bits);

  initial forever #25 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // waits for the frame strobe (1) or the running flag (0)
  task automatic wait_hi(input bit frm);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((frm ? frame_ok : out_status) !== 1'b1 && n < 9000);
    chk("wait", 1, frm ? frame_ok : out_status);
  endtask : wait_hi

  function automatic int sec_of(input logic [99:0] b);
    return b[4:1] + 10 * b[8:6];
  endfunction : sec_of

  function automatic int nxt(input int q, input logic leaped);
    return q == 59 ? (leaped ? 0 : 60) : (q == 60 ? 0 : q + 1);
  endfunction : nxt

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'h290d5dbc);
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    chk("status", 0, out_status);
    chk("ctrl", CTRL_RESET, ctrl_rdata);
    ctrl_wr = 1'b1;
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hffffffff : $urandom;
      ctrl_wdata = v[17:0];
      @(negedge clk_sys);
      chk("ctrl", v[17:0], ctrl_rdata);
    end
    ctrl_wr = 1'b0;
    leap_year_in = 7'($urandom_range(99));
    leap_day_in = 9'($urandom_range(365, 1));
    leap_hour_in = 5'($urandom_range(23));
    time_year_in = leap_year_in;
    time_day_in = leap_day_in;
    time_hour_in = leap_hour_in;
    time_min_in = 6'h3b;
    time_sec_in = 6'h36;
    cfg_type_in = 1'b1;
    cfg_pin_in = 4'($urandom_range(15, 1));
    {leap_wr, time_wr, cfg_wr} = 3'h7;
    @(negedge clk_sys);
    {leap_wr, time_wr, cfg_wr} = 3'h0;
    chk("leap year", leap_year_in, leap_year);
    chk("leap day", leap_day_in, leap_day);
    chk("leap hour", leap_hour_in, leap_hour);
    chk("pending", 1, leap_pending);
    chk("pin", cfg_pin_in, cfg_pin);
    chk("type", 1, cfg_type);
    out_enable = 1'b1;
    @(negedge clk_sys);
    out_enable = 1'b0;
    wait_hi(1'b0);
    chk("status", 1, out_status);
    seen = 1'b0;
    p = -1;
    for (int f = 0; f < 7; f++) begin
      wait_hi(1'b1);
      s = sec_of(bits);
      if (p >= 0) chk("second", nxt(p, seen), s);
      seen |= s == 60;
      p = s;
      chk("frame ctrl", v[17:0], {bits[78:70], bits[68:60]});
    end
    chk("leap seen", 1, seen);
    chk("pending", 0, leap_pending);
    chk("status", 1, out_status);
    out_disable = 1'b1;
    @(negedge clk_sys);
    out_disable = 1'b0;
    @(negedge clk_sys);
    chk("status", 0, out_status);
    chk("driving", 0, tc_oe);
    s = 0;
    repeat (4100) begin
      @(negedge clk_sys);
      s += frame_ok | tc_out | tc_oe;
    end
    chk("driven cycles", 0, s);
    {out_enable, out_reset} = 2'h3;
    @(negedge clk_sys);
    {out_enable, out_reset} = 2'h0;
    @(negedge clk_sys);
    chk("ctrl", CTRL_RESET, ctrl_rdata);
    chk("type", TYPE_RESET, cfg_type);
    chk("pin", PIN_RESET, cfg_pin);
    chk("leap year", 0, leap_year);
    chk("pending", 0, leap_pending);
    repeat (4100) @(negedge clk_sys);
    chk("status", 0, out_status);
    tally_and_finish();
  end
endmodule : tb_irig_master_ctrl
